// ===== core/tpic_timer.sv
// Purpose: 16-bit free-running timer with compare, capture, pwm and irq
// Assumes: halt_in and cpu_irq_mask_in come from cpu logic on clk_sys_in
// Notes:   registers on an 8-bit port, read data one cycle after strobe
`timescale 1ns/1ps
module tpic_timer
(
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic [3:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       capture_input_a_in,
  input  wire logic       capture_input_b_in,
  input  wire logic       ext_clk_in,
  input  wire logic       halt_in,
  input  wire logic       cpu_irq_mask_in,
  output logic            compare_output_a_out,
  output logic            compare_output_b_out,
  output logic            output_a_pin_enable_out,
  output logic            output_b_pin_enable_out,
  output logic            timer_irq_out,
  output logic            wake_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  ctrl_one_q;
  logic [7:0]  ctrl_two_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_b_q;
  logic [15:0] cap_a_q;
  logic [15:0] cap_b_q;
  logic        inhibit_a_q;
  logic        inhibit_b_q;
  logic [7:0]  flags_q;
  logic [7:0]  flags_d;
  logic [7:0]  seen_q;
  logic        arm_a_q;
  logic        arm_b_q;
  logic        halt_q;
  logic        out_a_q;
  logic        out_b_q;
  logic        irq_q;
  logic        wake_q;
  logic [7:0]  rdata_q;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic tick_raw;
  logic tick;
  logic edge_a;
  logic edge_b;
  logic pwm_mode;
  logic pulse_mode;
  logic match_a;
  logic match_b;
  logic pulse_start;
  logic cap_a_evt;
  logic cap_b_evt;
  logic halt_exit;
  logic cnt_write;
  logic ovf_evt;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       irq_req;

  function automatic logic access_at(input logic [3:0] a,
                                     input logic [3:0] off,
                                     input logic       strobe);
    access_at = strobe && (a == off);
  endfunction

  function automatic logic flag_next(input logic f,
                                     input logic set,
                                     input logic clr);
    // a set in the clearing cycle wins
    flag_next = set | (f & ~clr);
  endfunction

  // ----------------------------------------------------------------
  // clock and pin front end
  // ----------------------------------------------------------------
  // clock selection
  tpic_prescaler #(.DIV_W (3)) u_presc
  (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in),
    .select_in     (ctrl_two_q[tpic_pkg::CR2_CLK_HI:tpic_pkg::CR2_CLK_LO]),
    .ext_clk_in    (ext_clk_in),
    .ext_rising_in (ctrl_two_q[tpic_pkg::CR2_EXT_EDGE]),
    .tick_out      (tick_raw)
  );

  tpic_edge_sync u_cap_a
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pin_in     (capture_input_a_in),
    .rising_in  (ctrl_one_q[tpic_pkg::CR1_EDGE_A]),
    .edge_out   (edge_a)
  );

  tpic_edge_sync u_cap_b
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pin_in     (capture_input_b_in),
    .rising_in  (ctrl_two_q[tpic_pkg::CR2_EDGE_B]),
    .edge_out   (edge_b)
  );

  assign pwm_mode   = ctrl_two_q[tpic_pkg::CR2_PWM];
  assign pulse_mode = ctrl_two_q[tpic_pkg::CR2_PULSE] & ~pwm_mode;

  assign tick      = tick_raw & ~halt_in;
  assign halt_exit = halt_q & ~halt_in;

  // compare held off after high byte
  assign match_a = tick & ~inhibit_a_q & (cnt_q == cmp_a_q);
  assign match_b = tick & ~inhibit_b_q & (cnt_q == cmp_b_q);

  // input A ignored in pwm mode
  assign pulse_start = pulse_mode & edge_a & ~halt_in;
  assign cap_a_evt   = ~pwm_mode & ~pulse_mode & edge_a & ~halt_in;
  assign cap_b_evt   = edge_b & ~halt_in;

  assign cnt_write = access_at(addr_in, tpic_pkg::OFF_CNT_LO, wr_in) |
                     access_at(addr_in, tpic_pkg::OFF_ALT_LO, wr_in);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_write || pulse_start)
    begin
      cnt_d = tpic_pkg::CNT_RELOAD;
    end
    else if (pwm_mode && match_b)
    begin
      cnt_d = tpic_pkg::CNT_RELOAD;
    end
    else if (tick)
    begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  assign ovf_evt = tick & (cnt_q == tpic_pkg::CNT_MAX) & ~cnt_write &
                   ~pulse_start & ~(pwm_mode & match_b);

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cnt_q  <= tpic_pkg::CNT_RELOAD;
      halt_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      halt_q <= halt_in;
    end
  end

  // ----------------------------------------------------------------
  // control and compare registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ctrl_one_q <= tpic_pkg::CTRL_RESET;
      ctrl_two_q <= tpic_pkg::CTRL_RESET;
    end
    else if (wr_in)
    begin
      if (addr_in == tpic_pkg::OFF_CTRL_ONE)
      begin
        ctrl_one_q <= wdata_in;
      end
      if (addr_in == tpic_pkg::OFF_CTRL_TWO)
      begin
        ctrl_two_q <= wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cmp_a_q     <= tpic_pkg::CMP_RESET;
      cmp_b_q     <= tpic_pkg::CMP_RESET;
      inhibit_a_q <= 1'b0;
      inhibit_b_q <= 1'b0;
    end
    else if (wr_in)
    begin
      // high byte blocks, low byte releases
      case (addr_in)
        tpic_pkg::OFF_CMP_A_HI:
        begin
          cmp_a_q[15:8] <= wdata_in;
          inhibit_a_q   <= 1'b1;
        end
        tpic_pkg::OFF_CMP_A_LO:
        begin
          cmp_a_q[7:0] <= wdata_in;
          inhibit_a_q  <= 1'b0;
        end
        tpic_pkg::OFF_CMP_B_HI:
        begin
          cmp_b_q[15:8] <= wdata_in;
          inhibit_b_q   <= 1'b1;
        end
        tpic_pkg::OFF_CMP_B_LO:
        begin
          cmp_b_q[7:0] <= wdata_in;
          inhibit_b_q  <= 1'b0;
        end
        default:
        begin
          inhibit_a_q <= inhibit_a_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // capture registers and deep-stop arming
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      cap_a_q <= tpic_pkg::CAP_RESET;
      cap_b_q <= tpic_pkg::CAP_RESET;
      arm_a_q <= 1'b0;
      arm_b_q <= 1'b0;
    end
    else
    begin
      // arm in deep stop, capture at exit
      if (halt_in && edge_a && !pwm_mode && !pulse_mode)
      begin
        arm_a_q <= 1'b1;
      end
      else if (halt_exit)
      begin
        arm_a_q <= 1'b0;
      end
      if (halt_in && edge_b)
      begin
        arm_b_q <= 1'b1;
      end
      else if (halt_exit)
      begin
        arm_b_q <= 1'b0;
      end
      if (cap_a_evt || (halt_exit && arm_a_q))
      begin
        cap_a_q <= cnt_q;
      end
      else if (pulse_start)
      begin
        cap_a_q <= tpic_pkg::PULSE_CAP;
      end
      if (cap_b_evt || (halt_exit && arm_b_q))
      begin
        cap_b_q <= cnt_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_comb
  begin
    set_v = 8'h00;
    // period match sets capture flag A
    set_v[tpic_pkg::FL_CAP_A] = cap_a_evt | pulse_start |
                                (pwm_mode & match_b) |
                                (halt_exit & arm_a_q);
    set_v[tpic_pkg::FL_CAP_B] = cap_b_evt | (halt_exit & arm_b_q);
    // no compare flags in pwm mode
    set_v[tpic_pkg::FL_CMP_A] = match_a & ~pwm_mode & ~pulse_mode;
    set_v[tpic_pkg::FL_CMP_B] = match_b & ~pwm_mode;
    set_v[tpic_pkg::FL_OVF]   = ovf_evt;

    // second step of the clearing sequence
    clr_v = 8'h00;
    clr_v[tpic_pkg::FL_CAP_A] = access_at(addr_in, tpic_pkg::OFF_CAP_A_LO,
                                          rd_in | wr_in);
    clr_v[tpic_pkg::FL_CMP_A] = access_at(addr_in, tpic_pkg::OFF_CMP_A_LO,
                                          rd_in | wr_in);
    clr_v[tpic_pkg::FL_OVF]   = access_at(addr_in, tpic_pkg::OFF_CNT_LO,
                                          rd_in | wr_in);
    clr_v[tpic_pkg::FL_CAP_B] = access_at(addr_in, tpic_pkg::OFF_CAP_B_LO,
                                          rd_in | wr_in);
    clr_v[tpic_pkg::FL_CMP_B] = access_at(addr_in, tpic_pkg::OFF_CMP_B_LO,
                                          rd_in | wr_in);
    clr_v = clr_v & seen_q;

    for (int i = 0; i < 8; i++)
    begin
      flags_d[i] = flag_next(flags_q[i], set_v[i], clr_v[i]);
    end
    flags_d[2:0] = 3'h0;
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      flags_q <= 8'h00;
      seen_q  <= 8'h00;
    end
    else
    begin
      flags_q <= flags_d;
      // flag read arms clearing of flags set at that moment
      if (access_at(addr_in, tpic_pkg::OFF_FLAGS, rd_in))
      begin
        seen_q <= flags_q;
      end
      else
      begin
        seen_q <= seen_q & ~clr_v;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_a_q <= 1'b0;
    end
    else if (pwm_mode)
    begin
      // period level, equal levels hold steady
      if (match_b)
      begin
        out_a_q <= ctrl_one_q[tpic_pkg::CR1_LVL_B];
      end
      else if (match_a)
      begin
        out_a_q <= ctrl_one_q[tpic_pkg::CR1_LVL_A];
      end
    end
    // level B feeds output A in single pulse
    else if (pulse_mode)
    begin
      if (pulse_start)
      begin
        out_a_q <= ctrl_one_q[tpic_pkg::CR1_LVL_B];
      end
      else if (match_a)
      begin
        out_a_q <= ctrl_one_q[tpic_pkg::CR1_LVL_A];
      end
    end
    // match or forced copy of level A
    else if (ctrl_two_q[tpic_pkg::CR2_PIN_A] &&
             (match_a || ctrl_one_q[tpic_pkg::CR1_FORCE_A]))
    begin
      out_a_q <= ctrl_one_q[tpic_pkg::CR1_LVL_A];
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_b_q <= 1'b0;
    end
    // compare B match or forced copy of level B, never in pwm mode
    else if (!pwm_mode && ctrl_two_q[tpic_pkg::CR2_PIN_B] &&
             (match_b ||
              (!pulse_mode && ctrl_one_q[tpic_pkg::CR1_FORCE_B])))
    begin
      out_b_q <= ctrl_one_q[tpic_pkg::CR1_LVL_B];
    end
  end

  // ----------------------------------------------------------------
  // interrupt request and wake
  // ----------------------------------------------------------------
  // enables per kind: capture, compare, overflow
  assign irq_req =
    (ctrl_one_q[tpic_pkg::CR1_CAP_IE] &
     (flags_q[tpic_pkg::FL_CAP_A] | flags_q[tpic_pkg::FL_CAP_B])) |
    (ctrl_one_q[tpic_pkg::CR1_CMP_IE] &
     (flags_q[tpic_pkg::FL_CMP_A] | flags_q[tpic_pkg::FL_CMP_B])) |
    (ctrl_one_q[tpic_pkg::CR1_OVF_IE] & flags_q[tpic_pkg::FL_OVF]);

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      // shared line gated by cpu mask
      irq_q  <= irq_req & ~cpu_irq_mask_in;
      // wakes from sleep only, never from deep stop
      wake_q <= irq_req & ~cpu_irq_mask_in & ~halt_in;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_q <= 8'h00;
    end
    else if (rd_in)
    begin
      case (addr_in)
        tpic_pkg::OFF_CTRL_TWO: rdata_q <= ctrl_two_q;
        tpic_pkg::OFF_CTRL_ONE: rdata_q <= ctrl_one_q;
        tpic_pkg::OFF_FLAGS:    rdata_q <= flags_q;
        tpic_pkg::OFF_CAP_A_HI: rdata_q <= cap_a_q[15:8];
        tpic_pkg::OFF_CAP_A_LO: rdata_q <= cap_a_q[7:0];
        tpic_pkg::OFF_CMP_A_HI: rdata_q <= cmp_a_q[15:8];
        tpic_pkg::OFF_CMP_A_LO: rdata_q <= cmp_a_q[7:0];
        tpic_pkg::OFF_CMP_B_HI: rdata_q <= cmp_b_q[15:8];
        tpic_pkg::OFF_CMP_B_LO: rdata_q <= cmp_b_q[7:0];
        tpic_pkg::OFF_CNT_HI:   rdata_q <= cnt_q[15:8];
        tpic_pkg::OFF_CNT_LO:   rdata_q <= cnt_q[7:0];
        tpic_pkg::OFF_ALT_HI:   rdata_q <= cnt_q[15:8];
        tpic_pkg::OFF_ALT_LO:   rdata_q <= cnt_q[7:0];
        tpic_pkg::OFF_CAP_B_HI: rdata_q <= cap_b_q[15:8];
        tpic_pkg::OFF_CAP_B_LO: rdata_q <= cap_b_q[7:0];
        default:                rdata_q <= 8'h00;
      endcase
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_out               = rdata_q;
  assign compare_output_a_out    = out_a_q;
  assign compare_output_b_out    = out_b_q;
  // pin carries timer signal only when enabled
  assign output_a_pin_enable_out = ctrl_two_q[tpic_pkg::CR2_PIN_A];
  assign output_b_pin_enable_out = ctrl_two_q[tpic_pkg::CR2_PIN_B];
  assign timer_irq_out           = irq_q;
  assign wake_out                = wake_q;
endmodule

// ===== core/tpic_pkg.sv
// Purpose: constants shared by the timer modulation and interrupt block
// Assumes: 8-bit register port, one register per address
// Notes:   offsets are indices on the plain register port
package tpic_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL_TWO  = 4'h0;
  localparam logic [3:0] OFF_CTRL_ONE  = 4'h1;
  localparam logic [3:0] OFF_FLAGS     = 4'h2;
  localparam logic [3:0] OFF_CAP_A_HI  = 4'h3;
  localparam logic [3:0] OFF_CAP_A_LO  = 4'h4;
  localparam logic [3:0] OFF_CMP_A_HI  = 4'h5;
  localparam logic [3:0] OFF_CMP_A_LO  = 4'h6;
  localparam logic [3:0] OFF_CMP_B_HI  = 4'h7;
  localparam logic [3:0] OFF_CMP_B_LO  = 4'h8;
  localparam logic [3:0] OFF_CNT_HI    = 4'h9;
  localparam logic [3:0] OFF_CNT_LO    = 4'hA;
  localparam logic [3:0] OFF_ALT_HI    = 4'hB;
  localparam logic [3:0] OFF_ALT_LO    = 4'hC;
  localparam logic [3:0] OFF_CAP_B_HI  = 4'hD;
  localparam logic [3:0] OFF_CAP_B_LO  = 4'hE;

  // ----------------------------------------------------------------
  // control register one fields
  // ----------------------------------------------------------------
  localparam int CR1_CAP_IE   = 7;
  localparam int CR1_CMP_IE   = 6;
  localparam int CR1_OVF_IE   = 5;
  localparam int CR1_FORCE_B  = 4;
  localparam int CR1_FORCE_A  = 3;
  localparam int CR1_LVL_B    = 2;
  localparam int CR1_EDGE_A   = 1;
  localparam int CR1_LVL_A    = 0;

  // ----------------------------------------------------------------
  // control register two fields
  // ----------------------------------------------------------------
  localparam int CR2_PIN_A    = 7;
  localparam int CR2_PIN_B    = 6;
  localparam int CR2_PULSE    = 5;
  localparam int CR2_PWM      = 4;
  localparam int CR2_CLK_HI   = 3;
  localparam int CR2_CLK_LO   = 2;
  localparam int CR2_EDGE_B   = 1;
  localparam int CR2_EXT_EDGE = 0;

  // ----------------------------------------------------------------
  // flag register fields
  // ----------------------------------------------------------------
  localparam int FL_CAP_A = 7;
  localparam int FL_CMP_A = 6;
  localparam int FL_OVF   = 5;
  localparam int FL_CAP_B = 4;
  localparam int FL_CMP_B = 3;

  // ----------------------------------------------------------------
  // reset values and counter constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] CMP_RESET   = 16'h8000;
  localparam logic [15:0] CNT_RELOAD  = 16'hFFFC;
  localparam logic [15:0] PULSE_CAP   = 16'hFFFD;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [15:0] CAP_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // clock select codes and divide counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

// ===== core/tpic_edge_sync.sv
// Purpose: two-stage synchroniser and selectable edge detector for a pin
// Assumes: pin is asynchronous to clk_sys_in
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module tpic_edge_sync
(
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  input  wire logic rising_in,
  output logic      edge_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // rising_in high picks the rising edge, low the falling edge
  assign edge_out = rising_in ? (sync_q & ~last_q) : (~sync_q & last_q);
endmodule

// ===== core/tpic_prescaler.sv
// Purpose: timer tick from the system clock or the external clock pin
// Assumes: clk_sys_in is the cpu clock
// Notes:   tick is a one-cycle pulse
`timescale 1ns/1ps
module tpic_prescaler
#(
  parameter int DIV_W = 3
)
(
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  input  wire logic [1:0] select_in,
  input  wire logic       ext_clk_in,
  input  wire logic       ext_rising_in,
  output logic            tick_out
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] last_v;
  logic             ext_edge;

  if (DIV_W < 3)
  begin : g_chk
    $error("prescaler needs at least 3 bits to divide by 8");
  end

  tpic_edge_sync u_ext
  (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pin_in     (ext_clk_in),
    .rising_in  (ext_rising_in),
    .edge_out   (ext_edge)
  );

  always_comb
  begin
    case (select_in)
      tpic_pkg::CLK_DIV2: last_v = DIV_W'(tpic_pkg::DIV2_LAST);
      tpic_pkg::CLK_DIV8: last_v = DIV_W'(tpic_pkg::DIV8_LAST);
      default:            last_v = DIV_W'(tpic_pkg::DIV4_LAST);
    endcase
  end

  // ----------------------------------------------------------------
  // divider and tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_q    <= '0;
      tick_out <= 1'b0;
    end
    else if (select_in == tpic_pkg::CLK_EXT)
    begin
      div_q    <= '0;
      tick_out <= ext_edge;
    end
    else if (div_q >= last_v)
    begin
      div_q    <= '0;
      tick_out <= 1'b1;
    end
    else
    begin
      div_q    <= div_q + DIV_W'(1);
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== testbench/tpic_timer_properties.sv
// Purpose: port checks for the timer block
// Assumes: control writes are shadowed from the register port
// Notes:   quiet means three cycles without a write, to cover reg latency
`timescale 1ns/1ps
module tpic_timer_chk
(
  input wire logic       clk_sys_in,
  input wire logic       resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       halt_in,
  input wire logic       cpu_irq_mask_in,
  input wire logic       compare_output_a_out,
  input wire logic       compare_output_b_out,
  input wire logic       output_a_pin_enable_out,
  input wire logic       output_b_pin_enable_out,
  input wire logic       timer_irq_out,
  input wire logic       wake_out
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [1:0] gap_q;
  wire        quiet = (gap_q == 2'h3);
  always_ff @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in) {c1_q, c2_q} <= 16'h0000;
    else if (wr_in && addr_in == tpic_pkg::OFF_CTRL_ONE) c1_q <= wdata_in;
    else if (wr_in && addr_in == tpic_pkg::OFF_CTRL_TWO) c2_q <= wdata_in;
  always_ff @(posedge clk_sys_in or negedge resetn_in)
    if (!resetn_in) gap_q <= 2'h0;
    else gap_q <= wr_in ? 2'h0 : (quiet ? gap_q : gap_q + 2'h1);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);
  a_flag_low_zero: assert property ($past(rd_in) &&
    $past(addr_in) == tpic_pkg::OFF_FLAGS |-> rdata_out[2:0] == 3'h0)
    else $error("flag low bits set");
  a_ctrl_readback: assert property ($past(rd_in) && quiet &&
    $past(addr_in) == tpic_pkg::OFF_CTRL_ONE |-> rdata_out == c1_q)
    else $error("ctrl one readback");
  a_irq_masked: assert property ($past(cpu_irq_mask_in) |->
    !timer_irq_out) else $error("irq while masked");
  a_wake_follow: assert property (wake_out ==
    (timer_irq_out && !$past(halt_in))) else $error("wake mismatch");
  a_irq_no_enable: assert property (quiet && c1_q[7:5] == 3'h0 |->
    !timer_irq_out) else $error("irq with no enable");
  a_pin_enables: assert property (quiet |->
    output_a_pin_enable_out == c2_q[7] && output_b_pin_enable_out == c2_q[6])
    else $error("pin enable mismatch");
  a_pwm_level: assert property (quiet && c2_q[4] && c1_q[0] == c1_q[2]
    && $changed(compare_output_a_out) |-> compare_output_a_out == c1_q[0])
    else $error("pwm output left level");
  a_gpio_hold: assert property (quiet && c2_q[5:4] == 2'h0 |->
    (c2_q[7] || $stable(compare_output_a_out)) &&
    (c2_q[6] || $stable(compare_output_b_out))) else $error("pin moved");
endmodule
bind tpic_timer tpic_timer_chk chk_u (.clk_sys_in(clk_sys_in),
  .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .halt_in(halt_in),
  .cpu_irq_mask_in(cpu_irq_mask_in),
  .compare_output_a_out(compare_output_a_out),
  .compare_output_b_out(compare_output_b_out),
  .output_a_pin_enable_out(output_a_pin_enable_out),
  .output_b_pin_enable_out(output_b_pin_enable_out),
  .timer_irq_out(timer_irq_out), .wake_out(wake_out));

// ===== testbench/tpic_pins_model.sv
// Purpose: pin side: capture pulses, output A timing in clocks
// Assumes: capture pins idle high through a pull-up
// Notes:   blocking sampler reads pre-edge values, so no race
`timescale 1ns/1ps
module tpic_pins_model
(
  input  wire logic clk_sys_in,
  input  wire logic out_a_in,
  output logic      cap_a_out = 1'b1,
  output logic      cap_b_out = 1'b1,
  output int        high_out = 0,
  output int        period_out = 0,
  output int        rises_out = 0
);
  int   cnt = 0;
  logic prev = 1'b0;
  always @(posedge clk_sys_in)
  begin
    cnt = cnt + 1;
    if (out_a_in && !prev)
    begin
      period_out = cnt;
      rises_out = rises_out + 1;
      cnt = 0;
    end
    if (!out_a_in && prev) high_out = cnt;
    prev = out_a_in;
  end
  task automatic pulse(input logic on_a);
    {cap_a_out, cap_b_out} <= on_a ? 2'b01 : 2'b10;
    repeat (8) @(posedge clk_sys_in);
    {cap_a_out, cap_b_out} <= 2'b11;
  endtask
endmodule

// ===== testbench/tpic_timer_tb.sv
// Purpose: register-level bench for the timer block
// Assumes: pins model measures output A in system clocks
// Notes:   external clock pin toggles every cycle, one tick per two clocks
`timescale 1ns/1ps
module tpic_timer_tb;
  logic       clk, resetn, wr_s, rd_s, halt, mask, out_a, out_b, irq;
  logic       cap_a, cap_b, ext;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, r, q;
  int         err_total, n_compared, high, period, rises, k, dv;
  tpic_timer dut_u (.clk_sys_in(clk), .resetn_in(resetn), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata),
    .capture_input_a_in(cap_a), .capture_input_b_in(cap_b),
    .ext_clk_in(ext), .halt_in(halt), .cpu_irq_mask_in(mask),
    .compare_output_a_out(out_a), .compare_output_b_out(out_b),
    .output_a_pin_enable_out(), .output_b_pin_enable_out(),
    .timer_irq_out(irq), .wake_out());
  tpic_pins_model pins_u (.clk_sys_in(clk), .out_a_in(out_a),
    .cap_a_out(cap_a), .cap_b_out(cap_b), .high_out(high),
    .period_out(period), .rises_out(rises));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) ext <= ~ext;
  task automatic idle(input int n);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    rd_s <= 1'b0;
    wr_s <= 1'b1;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a);
    addr <= a;
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 r = rdata;
    @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    {resetn, wr_s, rd_s, halt, mask, addr, wdata, ext} = 18'h0_0000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd(tpic_pkg::OFF_CTRL_ONE);
    chk("ctrl one", r, 8'h00);
    rd(tpic_pkg::OFF_CMP_A_HI);
    chk("cmp hi", r, tpic_pkg::CMP_RESET[15:8]);
    // pwm entered first, so no normal match sets flags on the way
    wr(tpic_pkg::OFF_CTRL_TWO, 8'hB0);
    wr(tpic_pkg::OFF_CMP_B_HI, 8'h00);
    wr(tpic_pkg::OFF_CMP_B_LO, 8'h10);
    wr(tpic_pkg::OFF_CMP_A_HI, 8'h00);
    wr(tpic_pkg::OFF_CMP_A_LO, 8'h04);
    wr(tpic_pkg::OFF_CTRL_ONE, 8'h84);
    for (k = 0; k < 4; k++)
    begin
      dv = (k == 2) ? 8 : ((k == 0) ? 4 : 2);
      wr(tpic_pkg::OFF_CTRL_TWO, 8'hB0 | 8'(k << 2));
      idle(400);
      chk("period", 16'(period), 16'(21 * dv));
      chk("high", 16'(high), 16'(9 * dv));
    end
    $display("test pwm timing done");
    rd(tpic_pkg::OFF_FLAGS);
    chk("pwm flags", r & 8'hC8, 8'h80);
    chk("irq", irq, 1'b1);
    mask <= 1'b1;
    idle(2);
    chk("masked irq", irq, 1'b0);
    mask <= 1'b0;
    wr(tpic_pkg::OFF_CMP_B_HI, 8'h00);
    idle(4);
    k = rises;
    idle(400);
    chk("inhibit", 16'(rises - k), 16'h0000);
    wr(tpic_pkg::OFF_CMP_B_LO, 8'h10);
    wr(tpic_pkg::OFF_CNT_LO, 8'h00);
    idle(400);
    chk("resumed", 16'(rises > k), 16'h0001);
    wr(tpic_pkg::OFF_CTRL_ONE, 8'h85);
    idle(400);
    k = rises;
    idle(400);
    chk("flat", {out_a, 8'(rises - k)}, 16'h0100);
    pins_u.pulse(1'b1);
    pins_u.pulse(1'b0);
    idle(8);
    rd(tpic_pkg::OFF_CAP_A_LO);
    chk("cap a", r, tpic_pkg::CAP_RESET[7:0]);
    rd(tpic_pkg::OFF_FLAGS);
    chk("cap b flag", r[4], 1'b1);
    $display("test pwm side effects done");
    wr(tpic_pkg::OFF_CTRL_TWO, 8'h00);
    rd(tpic_pkg::OFF_FLAGS);
    rd(tpic_pkg::OFF_CAP_A_LO);
    rd(tpic_pkg::OFF_CAP_B_LO);
    rd(tpic_pkg::OFF_FLAGS);
    chk("cleared", r & 8'h90, 8'h00);
    wr(tpic_pkg::OFF_CTRL_ONE, 8'h20);
    wr(tpic_pkg::OFF_CNT_LO, 8'h00);
    idle(30);
    rd(tpic_pkg::OFF_FLAGS);
    chk("ovf irq", {r[5], irq}, 2'h3);
    rd(tpic_pkg::OFF_ALT_LO);
    rd(tpic_pkg::OFF_FLAGS);
    chk("alt keeps", {r[5], irq}, 2'h3);
    rd(tpic_pkg::OFF_CNT_LO);
    idle(2);
    chk("ovf clear", irq, 1'b0);
    $display("test flags done");
    halt <= 1'b1;
    idle(2);
    rd(tpic_pkg::OFF_CNT_LO);
    q = r;
    pins_u.pulse(1'b0);
    rd(tpic_pkg::OFF_CNT_LO);
    chk("frozen", r, q);
    halt <= 1'b0;
    idle(6);
    rd(tpic_pkg::OFF_FLAGS);
    chk("armed b", r[4], 1'b1);
    rd(tpic_pkg::OFF_CAP_B_LO);
    chk("exit capture", r, q);
    wr(tpic_pkg::OFF_CTRL_TWO, 8'hC0);
    wr(tpic_pkg::OFF_CTRL_ONE, 8'h1C);
    idle(2);
    rd(tpic_pkg::OFF_CTRL_ONE);
    chk("forced", {out_a, out_b}, 2'h1);
    $display("test halt and force done");
    give_verdict;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict;
  end
endmodule
